/* File: logic/motor_run_pkg.sv */
// constants and types shared by the motor run priority control block
package motor_run_pkg;
   // ==========================================================
   // register byte offsets (low address byte)
   localparam logic [7:0] CTRL_OFFSET   = 8'h00;
   localparam logic [7:0] CFG_OFFSET    = 8'h04;
   localparam logic [7:0] ROT_OFFSET    = 8'h08;
   localparam logic [7:0] EXTRA_OFFSET  = 8'h0c;
   localparam logic [7:0] RAMP_OFFSET   = 8'h10;
   localparam logic [7:0] STATUS_OFFSET = 8'h14;
   // ==========================================================
   // field positions
   localparam int RUN_BIT  = 7;
   localparam int DIR_BIT  = 0;
   localparam int HARD_BIT = 0;
   localparam int RUP_BIT  = 1;
   localparam int RDN_BIT  = 2;
   localparam int REV_BIT  = 3;
   localparam int XTRA_BIT = 4;
   localparam int EN0_BIT  = 5;
   localparam int EN1_BIT  = 6;
   localparam int CFG_W    = 7;
   localparam int CNT_W    = 16;
   // ==========================================================
   // reset values
   localparam logic [CFG_W-1:0] CFG_RESET   = 7'h00;
   localparam logic [CNT_W-1:0] ROT_RESET   = 16'h0010;
   localparam logic [CNT_W-1:0] EXTRA_RESET = 16'h0004;
   localparam logic [CNT_W-1:0] RAMP_RESET  = 16'h0008;
   // ==========================================================
   // step timing
   localparam int CLK_PERIOD_NS  = 5;
   localparam int STEP_PERIOD_NS = 50;
   localparam int STEP_CYCLES =
      (STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] STEP_RELOAD = 8'(STEP_CYCLES - 1);
   // ==========================================================
   // bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;
   typedef enum logic [2:0] {
      ST_IDLE, ST_RAMP_UP, ST_RUN, ST_EXTRA, ST_RAMP_DOWN
   } run_state_type;
endpackage : motor_run_pkg

/* File: logic/motor_run_priority_control.sv */
// motor run arbitration: stop request, ramps, sense-input actions
//
// Operation
// - ramp-up or ramp-down ignores all sense-interrupt actions.
// - at final speed, enabled sense interrupts change the motor run.
// - writing 0 to run bit is the only event acting during ramps.
// - stop in ramp-up with hard stop halts at once.
// - stop in ramp-up, no hard stop, ramp-down on: decelerate to stop.
// - stop in ramp-up, no hard stop, no ramp-down: halt at once.
// - stop during ramp-down with hard stop aborts ramp, halts at once.
// - stop during ramp-down without hard stop keeps ramping down.
// - reverse interrupt at speed flips direction, reloads rotations.
// - another reverse interrupt flips again, restarts rotation count.
// - rotations done without interrupt: ramp down if enabled.
// - with extra steps, run them first, then reverse.
// - sense inputs unfiltered; every level change of an input enabled by EN0_BIT or EN1_BIT is an event.
`timescale 1ns/100ps
module motor_run_priority_control (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic      [31:0] hrdata,
   output logic             hresp,
   input  wire logic        sense_input_zero,
   input  wire logic        sense_input_one,
   output logic             step_pulse,
   output logic             step_dir,
   output logic             motor_running
);
   // ==========================================================
   // declarations
   logic                               wr_q,   wr_d;
   logic [7:0]                         waddr_q, waddr_d;
   logic [31:0]                        rdata_q, rdata_d;
   logic                               ctrl_dir_q, ctrl_dir_d;
   logic [motor_run_pkg::CFG_W-1:0]    cfg_q,  cfg_d;
   logic [motor_run_pkg::CNT_W-1:0]    rot_q,  rot_d;
   logic [motor_run_pkg::CNT_W-1:0]    extra_q, extra_d;
   logic [motor_run_pkg::CNT_W-1:0]    ramp_q, ramp_d;
   motor_run_pkg::run_state_type       state_q, state_d;
   logic                               dir_q,  dir_d;
   logic [motor_run_pkg::CNT_W-1:0]    count_q, count_d;
   logic                               step_q, step_d;
   logic [7:0]                         tick_q, tick_d;
   logic [1:0]                         sense_prev_q;
   logic                               access, hi_zero, ctrl_wr, start_req;
   logic                               stop_req, tick, sense_hit, last_step;
   logic                               hard_en, rup_en, rdn_en;
   logic                               rev_en, xtra_en;
   motor_run_pkg::run_state_type       stop_state;

   assign hreadyout     = 1'b1;
   assign hresp         = motor_run_pkg::HRESP_OKAY;
   assign hrdata        = rdata_q;
   assign step_pulse    = step_q;
   assign step_dir      = dir_q;
   assign motor_running = (state_q != motor_run_pkg::ST_IDLE);

   assign hard_en = cfg_q[motor_run_pkg::HARD_BIT];
   assign rup_en  = cfg_q[motor_run_pkg::RUP_BIT];
   assign rdn_en  = cfg_q[motor_run_pkg::RDN_BIT];
   assign rev_en  = cfg_q[motor_run_pkg::REV_BIT];
   assign xtra_en = cfg_q[motor_run_pkg::XTRA_BIT];

   // ==========================================================
   // bus slave: address phase capture, read data, register writes
   assign access  = hsel & hready & (htrans == motor_run_pkg::HTRANS_NONSEQ);
   assign hi_zero = (haddr[31:8] == 24'h000000);
   assign ctrl_wr = wr_q & (waddr_q == motor_run_pkg::CTRL_OFFSET);

   always_comb begin
      wr_d       = access & hwrite & hi_zero;
      waddr_d    = access ? haddr[7:0] : waddr_q;
      rdata_d    = 32'h00000000;
      ctrl_dir_d = ctrl_dir_q;
      cfg_d      = cfg_q;
      rot_d      = rot_q;
      extra_d    = extra_q;
      ramp_d     = ramp_q;
      if (access & ~hwrite & hi_zero) begin
         case (haddr[7:0])
            motor_run_pkg::CTRL_OFFSET: begin
               rdata_d[motor_run_pkg::RUN_BIT] = motor_running;
               rdata_d[motor_run_pkg::DIR_BIT] = ctrl_dir_q;
            end
            motor_run_pkg::CFG_OFFSET:    rdata_d[6:0]  = cfg_q;
            motor_run_pkg::ROT_OFFSET:    rdata_d[15:0] = rot_q;
            motor_run_pkg::EXTRA_OFFSET:  rdata_d[15:0] = extra_q;
            motor_run_pkg::RAMP_OFFSET:   rdata_d[15:0] = ramp_q;
            motor_run_pkg::STATUS_OFFSET: begin
               rdata_d[31:16] = count_q;
               rdata_d[4]     = dir_q;
               rdata_d[2:0]   = state_q;
            end
            default:                      rdata_d = 32'h00000000;
         endcase
      end
      if (wr_q) begin
         case (waddr_q)
            motor_run_pkg::CTRL_OFFSET:
               ctrl_dir_d = hwdata[motor_run_pkg::DIR_BIT];
            motor_run_pkg::CFG_OFFSET:   cfg_d   = hwdata[6:0];
            motor_run_pkg::ROT_OFFSET:   rot_d   = hwdata[15:0];
            motor_run_pkg::EXTRA_OFFSET: extra_d = hwdata[15:0];
            motor_run_pkg::RAMP_OFFSET:  ramp_d  = hwdata[15:0];
            default:                     cfg_d   = cfg_q;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_q       <= 1'b0;
         waddr_q    <= 8'h00;
         rdata_q    <= 32'h00000000;
         ctrl_dir_q <= 1'b0;
         cfg_q      <= motor_run_pkg::CFG_RESET;
         rot_q      <= motor_run_pkg::ROT_RESET;
         extra_q    <= motor_run_pkg::EXTRA_RESET;
         ramp_q     <= motor_run_pkg::RAMP_RESET;
      end else begin
         wr_q       <= wr_d;
         waddr_q    <= waddr_d;
         rdata_q    <= rdata_d;
         ctrl_dir_q <= ctrl_dir_d;
         cfg_q      <= cfg_d;
         rot_q      <= rot_d;
         extra_q    <= extra_d;
         ramp_q     <= ramp_d;
      end
   end

   // ==========================================================
   // requests, step timing and sense events
   assign start_req = ctrl_wr & hwdata[motor_run_pkg::RUN_BIT] &
                      (state_q == motor_run_pkg::ST_IDLE);
   assign stop_req  = ctrl_wr & ~hwdata[motor_run_pkg::RUN_BIT] &
                      motor_running;
   assign tick      = motor_running & (tick_q == 8'h00);
   assign last_step = (count_q <= 16'h0001);
   assign sense_hit =
      ((sense_input_zero ^ sense_prev_q[0]) & cfg_q[motor_run_pkg::EN0_BIT]) |
      ((sense_input_one ^ sense_prev_q[1]) & cfg_q[motor_run_pkg::EN1_BIT]);

   always_comb begin
      tick_d = motor_run_pkg::STEP_RELOAD;
      if (motor_running && tick_q != 8'h00) begin
         tick_d = tick_q - 8'h01;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tick_q       <= 8'h00;
         sense_prev_q <= 2'b00;
      end else begin
         tick_q       <= tick_d;
         sense_prev_q <= {sense_input_one, sense_input_zero};
      end
   end

   // ==========================================================
   // run state machine
   always_comb begin
      // hard stop first, else ramp-down if enabled
      stop_state = (hard_en || !rdn_en) ? motor_run_pkg::ST_IDLE
                                        : motor_run_pkg::ST_RAMP_DOWN;
      state_d = state_q;
      dir_d   = dir_q;
      count_d = count_q;
      step_d  = 1'b0;
      case (state_q)
         motor_run_pkg::ST_IDLE: begin
            if (start_req) begin
               dir_d = hwdata[motor_run_pkg::DIR_BIT];
               if (rup_en && ramp_q != 16'h0000) begin
                  state_d = motor_run_pkg::ST_RAMP_UP;
                  count_d = ramp_q;
               end else begin
                  state_d = motor_run_pkg::ST_RUN;
                  count_d = rot_q;
               end
            end
         end
         motor_run_pkg::ST_RAMP_UP: begin
            if (stop_req) begin
               state_d = stop_state;
               count_d = ramp_q;
            end else if (tick) begin
               step_d  = 1'b1;
               count_d = last_step ? rot_q : count_q - 16'h0001;
               if (last_step) begin
                  state_d = motor_run_pkg::ST_RUN;
               end
            end
         end
         motor_run_pkg::ST_RUN: begin
            if (stop_req) begin
               state_d = stop_state;
               count_d = ramp_q;
            // act on sense at final speed
            end else if (sense_hit && rev_en) begin
               if (xtra_en && extra_q != 16'h0000) begin
                  state_d = motor_run_pkg::ST_EXTRA;
                  count_d = extra_q;
               end else begin
                  dir_d   = ~dir_q;
                  count_d = rot_q;
               end
            end else if (tick) begin
               step_d  = 1'b1;
               count_d = count_q - 16'h0001;
               if (last_step) begin
                  count_d = ramp_q;
                  if (rdn_en && ramp_q != 16'h0000) begin
                     state_d = motor_run_pkg::ST_RAMP_DOWN;
                  end else begin
                     state_d = motor_run_pkg::ST_IDLE;
                  end
               end
            end
         end
         motor_run_pkg::ST_EXTRA: begin
            if (stop_req) begin
               state_d = stop_state;
               count_d = ramp_q;
            end else if (tick) begin
               step_d  = 1'b1;
               count_d = count_q - 16'h0001;
               // reverse once extra steps are out
               if (last_step) begin
                  state_d = motor_run_pkg::ST_RUN;
                  dir_d   = ~dir_q;
                  count_d = rot_q;
               end
            end
         end
         motor_run_pkg::ST_RAMP_DOWN: begin
            if (stop_req && hard_en) begin
               state_d = motor_run_pkg::ST_IDLE;
            end else if (tick) begin
               step_d  = 1'b1;
               count_d = count_q - 16'h0001;
               if (last_step) begin
                  state_d = motor_run_pkg::ST_IDLE;
               end
            end
         end
         default: state_d = motor_run_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= motor_run_pkg::ST_IDLE;
         dir_q   <= 1'b0;
         count_q <= 16'h0000;
         step_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         dir_q   <= dir_d;
         count_q <= count_d;
         step_q  <= step_d;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   chk_ramp_up_deaf: assert property (
      (state_q == motor_run_pkg::ST_RAMP_UP && !stop_req && sense_hit)
      |=> dir_q == $past(dir_q) && state_q != motor_run_pkg::ST_EXTRA)
      else $error("sense event acted on during ramp-up");
   chk_ramp_down_only: assert property (
      (state_q == motor_run_pkg::ST_RAMP_DOWN && !stop_req)
      |=> state_q inside {motor_run_pkg::ST_RAMP_DOWN,
                          motor_run_pkg::ST_IDLE} && dir_q == $past(dir_q))
      else $error("ramp-down disturbed without stop request");
   chk_up_hard_stop: assert property (
      (state_q == motor_run_pkg::ST_RAMP_UP && stop_req && hard_en)
      |=> state_q == motor_run_pkg::ST_IDLE ##1 !step_pulse)
      else $error("hard stop in ramp-up did not halt");
   chk_up_soft_stop: assert property (
      (state_q == motor_run_pkg::ST_RAMP_UP && stop_req && !hard_en && rdn_en)
      |=> state_q == motor_run_pkg::ST_RAMP_DOWN && count_q == $past(ramp_q))
      else $error("soft stop in ramp-up did not ramp down");
   chk_up_plain_stop: assert property (
      (state_q == motor_run_pkg::ST_RAMP_UP && stop_req && !hard_en
       && !rdn_en) |=> state_q == motor_run_pkg::ST_IDLE)
      else $error("plain stop in ramp-up did not halt");
   chk_down_hard_stop: assert property (
      (state_q == motor_run_pkg::ST_RAMP_DOWN && stop_req && hard_en)
      |=> state_q == motor_run_pkg::ST_IDLE)
      else $error("hard stop did not abort ramp-down");
   chk_down_soft_keep: assert property (
      (state_q == motor_run_pkg::ST_RAMP_DOWN && stop_req && !hard_en
       && !last_step) |=> state_q == motor_run_pkg::ST_RAMP_DOWN)
      else $error("soft stop left ramp-down early");
   chk_run_reverse: assert property (
      (state_q == motor_run_pkg::ST_RUN && !stop_req && sense_hit && rev_en
       && !(xtra_en && extra_q != 16'h0000))
      |=> dir_q != $past(dir_q) && count_q == $past(rot_q))
      else $error("reverse on sense event missing");
   chk_run_to_ramp: assert property (
      (state_q == motor_run_pkg::ST_RUN && !stop_req && !sense_hit && tick
       && last_step && rdn_en && ramp_q != 16'h0000)
      |=> state_q == motor_run_pkg::ST_RAMP_DOWN)
      else $error("finished rotations did not ramp down");
   chk_extra_first: assert property (
      (state_q == motor_run_pkg::ST_RUN && !stop_req && sense_hit && rev_en
       && xtra_en && extra_q != 16'h0000)
      |=> state_q == motor_run_pkg::ST_EXTRA && dir_q == $past(dir_q))
      else $error("extra steps not taken before reverse");
   chk_raw_sense: assert property (
      (sense_input_zero != $past(sense_input_zero)
       && cfg_q[motor_run_pkg::EN0_BIT]) |-> sense_hit)
      else $error("sense level change not taken as event");

   cov_full_run: cover property (
      state_q == motor_run_pkg::ST_RUN ##1
      state_q == motor_run_pkg::ST_RAMP_DOWN);
   cov_double_reverse: cover property (
      (state_q == motor_run_pkg::ST_RUN && sense_hit && rev_en)
      ##[1:200] (state_q == motor_run_pkg::ST_RUN && sense_hit && rev_en));
   cov_hard_stop: cover property (
      state_q == motor_run_pkg::ST_RAMP_DOWN && stop_req && hard_en);
endmodule : motor_run_priority_control

/* File: verif/motor_host_model.sv */
// host model: ahb-lite master that issues run and stop requests
`timescale 1ns/100ps
module motor_host_model (
   input  wire logic        clk_sys,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic      [31:0] haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [2:0]  hsize,
   output logic      [31:0] hwdata
);
   initial begin
      hsel   = 1'h0;
      haddr  = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize  = 3'h2;
      hwdata = 32'h0;
   end
   // ==========================================================
   // single word transfer
   // stop request is a control write with run bit 0
   task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
             output logic [31:0] q);
      @(posedge clk_sys);
      hsel   <= 1'h1;
      haddr  <= a;
      htrans <= motor_run_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge clk_sys); while (hready !== 1'h1);
      hsel   <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wr ? d : ~hwdata;
      do @(posedge clk_sys); while (hready !== 1'h1);
      q = hrdata;
      // released bus shows no stale value
      hwdata <= ~d;
      haddr  <= ~a;
   endtask : xfer
endmodule : motor_host_model

/* File: verif/motor_run_priority_control_bench.sv */
// self-checking bench for the motor run priority control block
`timescale 1ns/100ps
module motor_run_priority_control_bench;
   logic        clk_sys, rst, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rq;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        sense_input_zero, sense_input_one;
   logic        step_pulse, step_dir, motor_running;
   int          errors, num_checks, steps, base;
   typedef struct packed {
      logic [31:0] off;
      logic        wr;
      logic [31:0] d;
      logic [31:0] exp;
   } row_type;
   row_type     rows [13];
   // ==========================================================
   // instances
   motor_host_model HOST (.clk_sys(clk_sys), .hready(hreadyout),
      .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   motor_run_priority_control DUT (.clk_sys(clk_sys), .rst(rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .sense_input_zero(sense_input_zero),
      .sense_input_one(sense_input_one), .step_pulse(step_pulse),
      .step_dir(step_dir), .motor_running(motor_running));
   initial begin
      clk_sys = 1'h0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (step_pulse === 1'h1) steps <= steps + 1;
   end
   // ==========================================================
   // helpers
   task check_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_word
   task check_pin(input logic got, input logic exp);
      check_word({31'h0, got}, {31'h0, exp});
   endtask : check_pin
   task reg_wr(input logic [7:0] off, input logic [31:0] d);
      HOST.xfer(1'h1, {24'h0, off}, d, rq);
   endtask : reg_wr
   task reg_rd(input logic [7:0] off);
      HOST.xfer(1'h0, {24'h0, off}, 32'h0, rq);
   endtask : reg_rd
   task settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : settle
   task check_state(input logic [2:0] s);
      reg_rd(motor_run_pkg::STATUS_OFFSET);
      check_word(rq & 32'h7, {29'h0, s});
   endtask : check_state
   task wait_state(input logic [2:0] s);
      int n;
      n = 0;
      do begin
         reg_rd(motor_run_pkg::STATUS_OFFSET);
         n++;
      end while (rq[2:0] !== s && n < 400);
      check_word({29'h0, rq[2:0]}, {29'h0, s});
   endtask : wait_state
   task toggle(input int which);
      @(posedge clk_sys);
      if (which == 0) sense_input_zero <= ~sense_input_zero;
      else sense_input_one <= ~sense_input_one;
   endtask : toggle
   task stop_req();
      reg_wr(motor_run_pkg::CTRL_OFFSET, 32'h0);
   endtask : stop_req
   task results();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   initial begin
      #500000;
      errors++;
      results();
   end
   // ==========================================================
   // main sequence
   initial begin
      rst = 1'h1;
      sense_input_zero = 1'h0;
      sense_input_one = 1'h0;
      steps = 0;
      rows = '{
         '{32'h00, 1'h0, 32'h0, 32'h0},
         '{32'h04, 1'h0, 32'h0, {25'h0, motor_run_pkg::CFG_RESET}},
         '{32'h08, 1'h0, 32'h0, {16'h0, motor_run_pkg::ROT_RESET}},
         '{32'h0c, 1'h0, 32'h0, {16'h0, motor_run_pkg::EXTRA_RESET}},
         '{32'h10, 1'h0, 32'h0, {16'h0, motor_run_pkg::RAMP_RESET}},
         '{32'h14, 1'h0, 32'h0, 32'h0},
         '{32'h18, 1'h1, 32'hffffffff, 32'h0},
         '{32'h100, 1'h1, 32'hffffffff, 32'h0},
         '{32'h00, 1'h0, 32'h0, 32'h0},
         '{32'h04, 1'h1, 32'hffffffff, 32'h7f},
         '{32'h08, 1'h1, 32'h00012345, 32'h2345},
         '{32'h14, 1'h1, 32'h0000ffff, 32'h0},
         '{32'h10, 1'h1, 32'h00000008, 32'h8}};
      repeat (16) @(posedge clk_sys);
      rst <= 1'h0;
      foreach (rows[i]) begin
         if (rows[i].wr) HOST.xfer(1'h1, rows[i].off, rows[i].d, rq);
         HOST.xfer(1'h0, rows[i].off, 32'h0, rq);
         check_word(rq, rows[i].exp);
      end
      reg_wr(motor_run_pkg::ROT_OFFSET, 32'h10);
      base = steps;
      reg_wr(motor_run_pkg::CFG_OFFSET, 32'h06);
      reg_wr(motor_run_pkg::CTRL_OFFSET, 32'h81);
      settle(2);
      check_pin(step_dir, 1'h1);
      wait_state(3'h0);
      settle(12);
      check_word(32'(steps - base), 32'd32);
      reg_wr(motor_run_pkg::CFG_OFFSET, 32'h07);
      reg_wr(motor_run_pkg::CTRL_OFFSET, 32'h80);
      settle(20);
      stop_req();
      settle(1);
      check_pin(motor_running, 1'h0);
      reg_wr(motor_run_pkg::CFG_OFFSET, 32'h02);
      reg_wr(motor_run_pkg::CTRL_OFFSET, 32'h80);
      settle(20);
      stop_req();
      check_state(3'h0);
      reg_wr(motor_run_pkg::CFG_OFFSET, 32'h06);
      reg_wr(motor_run_pkg::CTRL_OFFSET, 32'h80);
      settle(20);
      stop_req();
      check_state(3'h4);
      stop_req();
      check_state(3'h4);
      reg_wr(motor_run_pkg::CFG_OFFSET, 32'h07);
      stop_req();
      settle(1);
      check_pin(motor_running, 1'h0);
      reg_wr(motor_run_pkg::ROT_OFFSET, 32'h40);
      reg_wr(motor_run_pkg::CFG_OFFSET, 32'h6e);
      reg_wr(motor_run_pkg::CTRL_OFFSET, 32'h80);
      settle(20);
      toggle(0);
      settle(4);
      check_pin(step_dir, 1'h0);
      wait_state(3'h2);
      toggle(0);
      settle(4);
      check_pin(step_dir, 1'h1);
      settle(30);
      toggle(0);
      settle(4);
      check_pin(step_dir, 1'h0);
      reg_wr(motor_run_pkg::CFG_OFFSET, 32'h2e);
      toggle(1);
      settle(4);
      check_pin(step_dir, 1'h0);
      reg_wr(motor_run_pkg::CFG_OFFSET, 32'h7e);
      toggle(1);
      settle(3);
      check_state(3'h3);
      check_pin(step_dir, 1'h0);
      wait_state(3'h2);
      check_pin(step_dir, 1'h1);
      stop_req();
      toggle(0);
      settle(4);
      check_pin(step_dir, 1'h1);
      wait_state(3'h0);
      reg_wr(motor_run_pkg::CTRL_OFFSET, 32'h81);
      repeat (20) @(posedge clk_sys);
      rst <= 1'h1;
      settle(2);
      check_pin(motor_running, 1'h0);
      check_pin(step_dir, 1'h0);
      check_pin(step_pulse, 1'h0);
      check_pin(hreadyout, 1'h1);
      check_pin(hresp, motor_run_pkg::HRESP_OKAY);
      check_word(hrdata, 32'h0);
      @(posedge clk_sys);
      rst <= 1'h0;
      reg_rd(motor_run_pkg::CFG_OFFSET);
      check_word(rq, 32'h0);
      reg_rd(motor_run_pkg::ROT_OFFSET);
      check_word(rq, {16'h0, motor_run_pkg::ROT_RESET});
      results();
   end
endmodule : motor_run_priority_control_bench
